//--- hdl/uei_regs.sv
// Purpose: Event enable, status, latch, debug and spare registers
// Assumes: Sources are asynchronous comparator levels
// Notes:   Requests are single-cycle strobes on clk
`timescale 1ns/10ps
// Operation
// RULE_01: Rising enables bits 0-4, reset to one
// RULE_02: Falling enables bits 0-4, reset to one
// RULE_03: Detach bit meaningful only in host role
// RULE_04: Rising enable write/set/clear at 0Dh-0Fh
// RULE_05: Falling enable write/set/clear at 10h-12h
// RULE_06: Status at 13h shows live levels
// RULE_07: Status follows comparators, not reset value
// RULE_08: Enabled edge sets latch bit at 14h
// RULE_09: Reading latch returns contents then clears
// RULE_10: Debug at 15h shows line state
// RULE_11: Spare byte resets 00h, no effect
// RULE_12: Spare byte write/set/clear at 16h-18h
// RULE_13: Reserved bits read zero, writes ignored
// RULE_14: Edges found against previous-cycle level
module uei_regs
   import uei_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              arst_n,
   input  wire uei_req_t          req,
   output logic       [DATA_W-1:0] rdata,
   input  wire uei_src_t          src_async,
   input  wire logic              host_role,
   input  wire logic  [LS_W-1:0]  line_state_async
);
   // ******************************
   // Synchronisers
   // ******************************
   uei_src_t          src_m_r, src_s_r, src_p_r;
   uei_src_t          src_m_nxt, src_s_nxt, src_p_nxt;
   logic [LS_W-1:0]   ls_m_r, ls_s_r;
   logic [LS_W-1:0]   ls_m_nxt, ls_s_nxt;
   logic              vld_m_r, vld_s_r, src_valid_r;
   logic              vld_m_nxt, vld_s_nxt, src_valid_nxt;

   // Valid flag walks beside the data; reset-time zeros never count as an edge
   always_comb begin
      src_m_nxt     = src_async;
      src_s_nxt     = src_m_r;
      src_p_nxt     = src_s_r; // RULE_14
      ls_m_nxt      = line_state_async;
      ls_s_nxt      = ls_m_r;
      vld_m_nxt     = 1'b1;
      vld_s_nxt     = vld_m_r;
      src_valid_nxt = vld_s_r;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         src_m_r     <= '0;
         src_s_r     <= '0;
         src_p_r     <= '0;
         ls_m_r      <= '0;
         ls_s_r      <= '0;
         vld_m_r     <= 1'b0;
         vld_s_r     <= 1'b0;
         src_valid_r <= 1'b0;
      end else begin
         src_m_r     <= src_m_nxt;
         src_s_r     <= src_s_nxt;
         src_p_r     <= src_p_nxt;
         ls_m_r      <= ls_m_nxt;
         ls_s_r      <= ls_s_nxt;
         vld_m_r     <= vld_m_nxt;
         vld_s_r     <= vld_s_nxt;
         src_valid_r <= src_valid_nxt;
      end
   end

   // ******************************
   // Register state
   // ******************************
   logic [SRC_W-1:0]  rise_r, rise_nxt;
   logic [SRC_W-1:0]  fall_r, fall_nxt;
   logic [SRC_W-1:0]  latch_r, latch_nxt;
   logic [DATA_W-1:0] spare_r, spare_nxt;
   logic [DATA_W-1:0] rdata_nxt;
   logic [SRC_W-1:0]  src_now, src_old, evt, host_mask, wd_src;
   logic [DATA_W-1:0] rise_w, fall_w;

   // Write, set or clear of one register
   function automatic logic [DATA_W-1:0] wsc(input logic [DATA_W-1:0] cur,
                                             input uei_req_t          r,
                                             input logic [ADDR_W-1:0] wr_a,
                                             input logic [ADDR_W-1:0] set_a,
                                             input logic [ADDR_W-1:0] clr_a);
      logic [DATA_W-1:0] v;
      v = cur;
      if (r.wr && r.addr == wr_a)
         v = r.wdata;
      else if (r.wr && r.addr == set_a)
         v = cur | r.wdata;
      else if (r.wr && r.addr == clr_a)
         v = cur & ~r.wdata;
      return v;
   endfunction

   always_comb begin
      src_now   = src_s_r;
      src_old   = src_p_r;
      wd_src    = req.wdata[SRC_W-1:0];
      // Detach only tracked as host; keeps device role quiet
      host_mask = {{(SRC_W-1){1'b1}}, host_role}; // RULE_03
      // No edges until the valid flag has reached the history stage
      evt       = src_valid_r ? host_mask & ((rise_r & src_now & ~src_old) |
                                  (fall_r & ~src_now & src_old)) : '0; // RULE_08
      // Upper bits dropped here, so reserved enable bits never store
      rise_w    = wsc(DATA_W'(rise_r), req, RISE_WR_A, RISE_SET_A, RISE_CLR_A); // RULE_04
      fall_w    = wsc(DATA_W'(fall_r), req, FALL_WR_A, FALL_SET_A, FALL_CLR_A); // RULE_05
      rise_nxt  = rise_w[SRC_W-1:0]; // RULE_01 RULE_13
      fall_nxt  = fall_w[SRC_W-1:0]; // RULE_02 RULE_13
      spare_nxt = wsc(spare_r, req, SPARE_WR_A, SPARE_SET_A, SPARE_CLR_A); // RULE_11 RULE_12
      // Set beats the read clear so no edge is lost
      latch_nxt = ((req.rd && req.addr == LATCH_A) ? '0 : latch_r) | evt; // RULE_09 RULE_08
      rdata_nxt = RD_ZERO;
      if (req.rd) begin
         unique case (req.addr)
            RISE_WR_A, RISE_SET_A, RISE_CLR_A: rdata_nxt = {3'b000, rise_r};
            FALL_WR_A, FALL_SET_A, FALL_CLR_A: rdata_nxt = {3'b000, fall_r};
            STAT_A:  rdata_nxt = {3'b000, host_mask & src_now}; // RULE_06 RULE_07
            LATCH_A: rdata_nxt = {3'b000, latch_r}; // RULE_09
            DEBUG_A: rdata_nxt = {6'b00_0000, ls_s_r}; // RULE_10 RULE_13
            SPARE_WR_A, SPARE_SET_A, SPARE_CLR_A: rdata_nxt = spare_r;
            default: rdata_nxt = RD_ZERO;
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rise_r  <= EN_RST;
         fall_r  <= EN_RST;
         latch_r <= LATCH_RST;
         spare_r <= SPARE_RST;
         rdata   <= RD_ZERO;
      end else begin
         rise_r  <= rise_nxt;
         fall_r  <= fall_nxt;
         latch_r <= latch_nxt;
         spare_r <= spare_nxt;
         rdata   <= rdata_nxt;
      end
   end

   // ******************************
   // Checks
   // ******************************
   a_latch_sets: assert property (@(posedge clk) disable iff (!arst_n) // RULE_08
      (src_valid_r && rise_r[1] && src_s_r[1] && !src_p_r[1]) |=> latch_r[1])
      else $error("enabled rising edge not latched");
   a_latch_rdclr: assert property (@(posedge clk) disable iff (!arst_n) // RULE_09
      (req.rd && req.addr == LATCH_A && evt == '0) |=>
      (latch_r == '0 && rdata == DATA_W'($past(latch_r))))
      else $error("latch read did not clear");
   a_latch_keep: assert property (@(posedge clk) disable iff (!arst_n) // RULE_08
      (req.rd && req.addr == LATCH_A) |=> ((latch_r & $past(evt)) == $past(evt)))
      else $error("event lost under latch read");
   a_latch_hold: assert property (@(posedge clk) disable iff (!arst_n) // RULE_09
      (!(req.rd && req.addr == LATCH_A) && evt == '0) |=> $stable(latch_r))
      else $error("latch changed without event or read");
   a_arm_quiet: assert property (@(posedge clk) disable iff (!arst_n) // RULE_14
      !src_valid_r |=> ((latch_r & ~$past(latch_r)) == '0))
      else $error("event latched before edge history valid");
   a_rise_wr: assert property (@(posedge clk) disable iff (!arst_n) // RULE_04
      (req.wr && req.addr == RISE_WR_A) |=> (rise_r == $past(wd_src)))
      else $error("rising write failed");
   a_rise_set: assert property (@(posedge clk) disable iff (!arst_n) // RULE_04
      (req.wr && req.addr == RISE_SET_A) |=> ((rise_r & $past(wd_src)) == $past(wd_src)))
      else $error("rising set failed");
   a_rise_clr: assert property (@(posedge clk) disable iff (!arst_n) // RULE_04
      (req.wr && req.addr == RISE_CLR_A) |=> ((rise_r & $past(wd_src)) == '0))
      else $error("rising clear failed");
   a_fall_wr: assert property (@(posedge clk) disable iff (!arst_n) // RULE_05
      (req.wr && req.addr == FALL_WR_A) |=> (fall_r == $past(wd_src)))
      else $error("falling write failed");
   a_fall_set: assert property (@(posedge clk) disable iff (!arst_n) // RULE_05
      (req.wr && req.addr == FALL_SET_A) |=> ((fall_r & $past(wd_src)) == $past(wd_src)))
      else $error("falling set failed");
   a_fall_clr: assert property (@(posedge clk) disable iff (!arst_n) // RULE_05
      (req.wr && req.addr == FALL_CLR_A) |=> ((fall_r & $past(wd_src)) == '0))
      else $error("falling clear failed");
   a_spare_wr: assert property (@(posedge clk) disable iff (!arst_n) // RULE_12
      (req.wr && req.addr == SPARE_WR_A) |=> (spare_r == $past(req.wdata)))
      else $error("spare write failed");
   a_spare_set: assert property (@(posedge clk) disable iff (!arst_n) // RULE_12
      (req.wr && req.addr == SPARE_SET_A) |=> ((spare_r & $past(req.wdata)) == $past(req.wdata)))
      else $error("spare set failed");
   a_spare_clr: assert property (@(posedge clk) disable iff (!arst_n) // RULE_12
      (req.wr && req.addr == SPARE_CLR_A) |=> ((spare_r & $past(req.wdata)) == '0))
      else $error("spare clear failed");
   a_spare_read: assert property (@(posedge clk) disable iff (!arst_n) // RULE_12
      (req.rd && req.addr == SPARE_SET_A) |=> (rdata == $past(spare_r)))
      else $error("spare read wrong");
   a_ro_ignored: assert property (@(posedge clk) disable iff (!arst_n) // RULE_13
      (req.wr && req.addr >= STAT_A && req.addr <= DEBUG_A) |=>
      ($stable(rise_r) && $stable(fall_r) && $stable(spare_r)))
      else $error("read-only write changed state");
   a_stat_read: assert property (@(posedge clk) disable iff (!arst_n) // RULE_06
      (req.rd && req.addr == STAT_A) |=>
      (rdata[DATA_W-1:SRC_W] == '0 && rdata[1] == $past(src_s_r[1])))
      else $error("status read wrong");
   a_detach_dev: assert property (@(posedge clk) disable iff (!arst_n) // RULE_03
      (req.rd && req.addr == STAT_A && !host_role) |=> !rdata[0])
      else $error("detach shown outside host role");
   a_debug_read: assert property (@(posedge clk) disable iff (!arst_n) // RULE_10
      (req.rd && req.addr == DEBUG_A) |=> (rdata == {6'b00_0000, $past(ls_s_r)}))
      else $error("debug read wrong");
   a_resv_zero: assert property (@(posedge clk) disable iff (!arst_n) // RULE_13
      (req.rd && req.addr >= RISE_WR_A && req.addr <= LATCH_A) |=> (rdata[DATA_W-1:SRC_W] == '0))
      else $error("reserved bits not zero");
   a_unmapped_zero: assert property (@(posedge clk) disable iff (!arst_n) // RULE_13
      (req.rd && (req.addr < RISE_WR_A || req.addr > SPARE_CLR_A)) |=> (rdata == RD_ZERO))
      else $error("unmapped read not zero");
   a_no_detach_dev: assert property (@(posedge clk) disable iff (!arst_n) // RULE_03
      (!host_role && !latch_r[0]) |=> !latch_r[0])
      else $error("detach latched outside host role");
   a_fall_edge: assert property (@(posedge clk) disable iff (!arst_n) // RULE_14
      (src_valid_r && fall_r[2] && !src_s_r[2] && src_p_r[2]) |=> latch_r[2])
      else $error("enabled falling edge not latched");
endmodule

//--- hdl/uei_pkg.sv
// Purpose: Constants and types for the USB event register group
// Assumes: Byte-wide register port, 6-bit address
// Notes:   Offsets are register-port addresses
package uei_pkg;
   localparam int unsigned ADDR_W = 6;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned SRC_W  = 5;
   localparam int unsigned LS_W   = 2;

   // ******************************
   // Register addresses
   // ******************************
   localparam logic [ADDR_W-1:0] RISE_WR_A  = 6'h0d;
   localparam logic [ADDR_W-1:0] RISE_SET_A = 6'h0e;
   localparam logic [ADDR_W-1:0] RISE_CLR_A = 6'h0f;
   localparam logic [ADDR_W-1:0] FALL_WR_A  = 6'h10;
   localparam logic [ADDR_W-1:0] FALL_SET_A = 6'h11;
   localparam logic [ADDR_W-1:0] FALL_CLR_A = 6'h12;
   localparam logic [ADDR_W-1:0] STAT_A     = 6'h13;
   localparam logic [ADDR_W-1:0] LATCH_A    = 6'h14;
   localparam logic [ADDR_W-1:0] DEBUG_A    = 6'h15;
   localparam logic [ADDR_W-1:0] SPARE_WR_A  = 6'h16;
   localparam logic [ADDR_W-1:0] SPARE_SET_A = 6'h17;
   localparam logic [ADDR_W-1:0] SPARE_CLR_A = 6'h18;

   // ******************************
   // Reset values
   // ******************************
   localparam logic [SRC_W-1:0]  EN_RST    = 5'h1f;
   localparam logic [SRC_W-1:0]  LATCH_RST = 5'h00;
   localparam logic [DATA_W-1:0] SPARE_RST = 8'h00;
   localparam logic [DATA_W-1:0] RD_ZERO   = 8'h00;

   // Source bit order
   typedef struct packed {
      logic id_pin_grounded;
      logic session_ended_flag;
      logic session_valid_flag;
      logic bus_power_valid;
      logic downstream_detach;
   } uei_src_t;

   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } uei_req_t;
endpackage

//--- dv/uei_link.sv
// Purpose: Link-side model issuing register-port requests
// Assumes: One request at a time, driven on the falling edge
// Notes:   Read data taken one cycle after the strobe
`timescale 1ns/10ps
module uei_link
   import uei_pkg::*;
(
   input  wire logic              clk,
   output uei_req_t               req,
   input  wire logic [DATA_W-1:0] rdata
);
   initial req = '0;
   // Strobe held for exactly one rising edge, then dropped
   task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
      @(negedge clk);
      req.wr    = w;
      req.rd    = !w;
      req.addr  = a;
      req.wdata = d;
      @(negedge clk);
      q      = rdata;
      req.wr = 1'b0;
      req.rd = 1'b0;
   endtask
endmodule

//--- dv/usb_event_interrupt_regs_test.sv
// Purpose: Self-checking bench for the event register group
// Assumes: Source and line levels held steady between checks
// Notes:   Settle wait covers the 2-flop sync plus edge stage
`timescale 1ns/10ps
module usb_event_interrupt_regs_test
   import uei_pkg::*;
;
   logic              clk = 1'b0;
   logic              arst_n = 1'b0;
   uei_req_t          req;
   logic [DATA_W-1:0] rdata;
   uei_src_t          src = 5'h0a;
   logic              host_role = 1'b1;
   logic [LS_W-1:0]   ls = 2'h2;
   int                failures = 0;
   int                tests_run = 0;
   int                cycles = 0;
   logic [DATA_W-1:0] q;
   logic [DATA_W-1:0] m;
   logic [ADDR_W-1:0] b;

   initial forever #2 clk = ~clk;
   uei_link i_link (.clk(clk), .req(req), .rdata(rdata));
   uei_regs i_dut (.clk(clk), .arst_n(arst_n), .req(req), .rdata(rdata),
                   .src_async(src), .host_role(host_role), .line_state_async(ls));

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      logic [DATA_W-1:0] dummy;
      i_link.xfer(1'b1, a, d, dummy);
   endtask
   task automatic chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      logic [DATA_W-1:0] got;
      i_link.xfer(1'b0, a, 8'h00, got);
      tests_run++;
      if (got !== e) begin
         failures++;
         $display("ERROR reg %h expected %h seen %h", a, e, got);
      end
   endtask
   task automatic settle();
      repeat (5) @(negedge clk);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Ceiling well above the roughly 160 cycles the sequence needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         close_out();
      end
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (5) @(negedge clk);
      arst_n = 1'b1;
      settle();
      chk(RISE_WR_A, 8'h1f);
      chk(RISE_CLR_A, 8'h1f);
      chk(FALL_SET_A, 8'h1f);
      chk(SPARE_WR_A, 8'h00);
      chk(LATCH_A, 8'h00);
      chk(STAT_A, 8'h0a);
      chk(DEBUG_A, 8'h02);
      for (int g = 0; g < 3; g++) begin
         b = (g == 0) ? RISE_WR_A : (g == 1) ? FALL_WR_A : SPARE_WR_A;
         m = (g == 2) ? 8'hff : 8'h1f;
         wr(b, 8'hff);
         chk(b, m);
         wr(b + 6'h02, 8'h05);
         chk(b + 6'h01, m & 8'hfa);
         wr(b + 6'h01, 8'h01);
         chk(b + 6'h02, m & 8'hfb);
      end
      src = 5'h0e;
      settle();
      chk(LATCH_A, 8'h00);
      src = 5'h0c;
      settle();
      chk(LATCH_A, 8'h02);
      chk(LATCH_A, 8'h00);
      wr(STAT_A, 8'hff);
      chk(STAT_A, 8'h0c);
      host_role = 1'b0;
      src = 5'h0d;
      settle();
      chk(STAT_A, 8'h0c);
      chk(LATCH_A, 8'h00);
      host_role = 1'b1;
      settle();
      chk(STAT_A, 8'h0d);
      src = 5'h0c;
      settle();
      chk(LATCH_A, 8'h01);
      ls = 2'h1;
      settle();
      chk(DEBUG_A, 8'h01);
      chk(6'h3f, 8'h00);
      // Edge lands in the same cycle as the latch read; set must win
      src = 5'h1c;
      @(negedge clk);
      chk(LATCH_A, 8'h00);
      chk(LATCH_A, 8'h10);
      // Mid-run reset with sources high; no event from reset-time levels
      arst_n = 1'b0;
      src = 5'h1e;
      repeat (5) @(negedge clk);
      arst_n = 1'b1;
      settle();
      chk(LATCH_A, 8'h00);
      chk(RISE_SET_A, 8'h1f);
      chk(FALL_CLR_A, 8'h1f);
      chk(SPARE_SET_A, 8'h00);
      chk(STAT_A, 8'h1e);
      src = 5'h1a;
      settle();
      chk(LATCH_A, 8'h04);
      src = 5'h18;
      settle();
      chk(LATCH_A, 8'h02);
      src = 5'h1a;
      settle();
      chk(LATCH_A, 8'h02);
      close_out();
   end
endmodule
